// ### logic/tsc_capture.v
`timescale 1ns/1ps
`default_nettype none
`include "tsc_map.vh"

module tsc_capture #(
    parameter GW  = 16,
    parameter NG  = 4,
    parameter SW  = 2,
    parameter AW  = 8,
    parameter NWP = 4,
    parameter NBP = 4,
    parameter BW  = 2,
    parameter MW  = 4
) (
    input  wire                  sys_clk_i,
    input  wire                  rst_i,
    input  wire [NG*GW-1:0]      grp_data_i,
    input  wire [SW-1:0]         grp_sel_i,
    input  wire                  arm_i,
    input  wire                  stop_i,
    input  wire [NWP-1:0]        wp_en_i,
    input  wire [NWP-1:0]        wp_trans_i,
    input  wire [NWP*GW-1:0]     wp_first_i,
    input  wire [NWP*GW-1:0]     wp_second_i,
    input  wire [NWP*GW-1:0]     wp_care_i,
    input  wire [NBP-1:0]        bp_en_i,
    input  wire [NBP-1:0]        bp_hit_i,
    input  wire [1:0]            trig_pos_i,
    input  wire                  comp_en_i,
    input  wire                  mask_en_i,
    input  wire [MW-1:0]         mask_msb_i,
    input  wire [MW-1:0]         mask_lsb_i,
    input  wire [AW-1:0]         rd_idx_i,
    input  wire                  rd_done_i,
    output wire                  running_o,
    output reg                   new_data_o,
    output reg                   bp_trig_o,
    output reg  [BW-1:0]         bp_idx_o,
    output reg  [AW:0]           count_o,
    output reg  [GW-1:0]         rd_data_o,
    output reg  [`TSC_SKIP_W-1:0] rd_skip_o,
    output reg  signed [AW:0]    rd_rel_o
);

localparam DEPTH = 1 << AW;
localparam [AW:0] DEPTH_W = {1'b1, {AW{1'b0}}};
localparam EW = GW + `TSC_SKIP_W;

// one-hot states
localparam [3:0] S_IDLE = 4'h1;
localparam [3:0] S_PRE  = 4'h2;
localparam [3:0] S_POST = 4'h4;
localparam [3:0] S_DONE = 4'h8;

// =====================================================
// helper functions
function [GW-1:0] range_mask;
    input [MW-1:0] msb;
    input [MW-1:0] lsb;
    integer i;
    begin
        range_mask = {GW{1'b0}};
        for (i = 0; i < GW; i = i + 1)
            range_mask[i] = (i >= lsb) && (i <= msb);
    end
endfunction

function [BW-1:0] first_set;
    input [NBP-1:0] v;
    integer i;
    begin
        first_set = {BW{1'b0}};
        for (i = NBP - 1; i >= 0; i = i - 1)
            if (v[i])
                first_set = i[BW-1:0];
    end
endfunction

function [AW:0] post_len;
    input [1:0] pos;
    begin
        case (pos)
            `TSC_POS_EARLY: post_len = DEPTH_W - (DEPTH_W >> `TSC_EDGE_SHIFT);
            `TSC_POS_LATE:  post_len = DEPTH_W >> `TSC_EDGE_SHIFT;
            default:        post_len = DEPTH_W >> `TSC_MID_SHIFT;
        endcase
    end
endfunction

// =====================================================
// run settings, captured at arm
reg  [3:0]        state;
reg  [SW-1:0]     sel_q;
reg               comp_q;
reg  [GW-1:0]     mask_q;
reg  [1:0]        pos_q;
reg  [NWP-1:0]    wp_en_q;
reg  [NWP-1:0]    wp_trans_q;
reg  [NWP*GW-1:0] wp_first_q;
reg  [NWP*GW-1:0] wp_second_q;
reg  [NWP*GW-1:0] wp_care_q;
reg  [NBP-1:0]    bp_en_q;

// activations and options latched when the host arms
always @(posedge sys_clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        sel_q       <= {SW{1'b0}};
        comp_q      <= 1'b0;
        mask_q      <= {GW{1'b0}};
        pos_q       <= `TSC_POS_MIDDLE;
        wp_en_q     <= {NWP{1'b0}};
        wp_trans_q  <= {NWP{1'b0}};
        wp_first_q  <= {NWP*GW{1'b0}};
        wp_second_q <= {NWP*GW{1'b0}};
        wp_care_q   <= {NWP*GW{1'b0}};
        bp_en_q     <= {NBP{1'b0}};
    end
    else if (arm_i)
    begin
        sel_q       <= grp_sel_i;
        comp_q      <= comp_en_i;
        mask_q      <= mask_en_i ? range_mask(mask_msb_i, mask_lsb_i) : {GW{1'b0}};
        pos_q       <= trig_pos_i;
        wp_en_q     <= wp_en_i;
        wp_trans_q  <= wp_trans_i;
        wp_first_q  <= wp_first_i;
        wp_second_q <= wp_second_i;
        wp_care_q   <= wp_care_i;
        bp_en_q     <= bp_en_i;
    end
end

// =====================================================
// selected group and trigger sources
wire [GW-1:0]  cur = grp_data_i[sel_q*GW +: GW];
wire [NWP-1:0] wp_hit;
wire [NBP-1:0] bp_act = bp_hit_i & bp_en_q;
wire           sampling = (state == S_PRE) || (state == S_POST);

// one compare per watchpoint instance
genvar g;
generate
    for (g = 0; g < NWP; g = g + 1)
    begin : g_wp
        tsc_watch #(.W(GW)) u_watch (
            .sys_clk_i (sys_clk_i),
            .rst_i     (rst_i),
            .en_i      (wp_en_q[g] & sampling),
            .trans_i   (wp_trans_q[g]),
            .first_i   (wp_first_q[g*GW +: GW]),
            .second_i  (wp_second_q[g*GW +: GW]),
            .care_i    (wp_care_q[g*GW +: GW]),
            .data_i    (cur),
            .hit_o     (wp_hit[g])
        );
    end
endgenerate

wire trig = (state == S_PRE) && ((|wp_hit) || (|bp_act));

// =====================================================
// compression decision
reg  [GW-1:0]           prev;
reg                     first;
reg  [`TSC_SKIP_W-1:0]  skip;
wire changed = |((cur ^ prev) & ~mask_q);
wire run_max = skip == (`TSC_RUN_MAX - 7'h01);
wire store   = sampling && (!comp_q || changed || run_max || trig || first);

// =====================================================
// sample memory and control
reg  [EW-1:0] mem [0:DEPTH-1];
reg  [AW-1:0] wptr;
reg  [AW-1:0] trig_addr;
reg  [AW:0]   post_left;

// circular store of samples with their skip counts
always @(posedge sys_clk_i)
begin
    if (store)
        mem[wptr] <= {skip, cur};
end

// capture state machine
always @(posedge sys_clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        state      <= S_IDLE;
        prev       <= {GW{1'b0}};
        first      <= 1'b0;
        skip       <= {`TSC_SKIP_W{1'b0}};
        wptr       <= {AW{1'b0}};
        trig_addr  <= {AW{1'b0}};
        post_left  <= {AW+1{1'b0}};
        count_o    <= {AW+1{1'b0}};
        new_data_o <= 1'b0;
        bp_trig_o  <= 1'b0;
        bp_idx_o   <= {BW{1'b0}};
    end
    else
    begin
        prev <= cur;
        if (arm_i)
        begin
            state      <= S_PRE;
            first      <= 1'b1;
            skip       <= {`TSC_SKIP_W{1'b0}};
            wptr       <= {AW{1'b0}};
            count_o    <= {AW+1{1'b0}};
            new_data_o <= 1'b0;
            bp_trig_o  <= 1'b0;
        end
        else if (stop_i && sampling)
            state <= S_IDLE;                      // abandoned run, no new data
        else
        begin
            if (sampling)
            begin
                first <= 1'b0;
                if (store)
                begin
                    wptr <= wptr + {{AW-1{1'b0}}, 1'b1};
                    skip <= {`TSC_SKIP_W{1'b0}};
                    if (count_o != DEPTH_W)
                        count_o <= count_o + {{AW{1'b0}}, 1'b1};
                end
                else
                    skip <= skip + 7'h01;
            end
            case (state)
                S_PRE:
                begin
                    if (trig)
                    begin
                        trig_addr <= wptr;
                        post_left <= post_len(pos_q);
                        state     <= S_POST;
                        bp_trig_o <= |bp_act;
                        bp_idx_o  <= first_set(bp_act);
                    end
                end
                S_POST:
                begin
                    if (store)
                    begin
                        post_left <= post_left - {{AW{1'b0}}, 1'b1};
                        if (post_left == {{AW{1'b0}}, 1'b1})
                        begin
                            state      <= S_DONE;
                            new_data_o <= 1'b1;
                        end
                    end
                end
                S_DONE:
                begin
                    if (rd_done_i)
                        new_data_o <= 1'b0;
                end
                S_IDLE:
                begin
                    if (rd_done_i)
                        new_data_o <= 1'b0;
                end
                default:
                    state <= S_IDLE;
            endcase
        end
    end
end

assign running_o = sampling;

// =====================================================
// readback, oldest entry first, numbered from trigger
wire [AW-1:0] base     = (count_o == DEPTH_W) ? wptr : {AW{1'b0}};
wire [AW-1:0] trig_idx = trig_addr - base;
wire [AW-1:0] rd_addr  = base + rd_idx_i;

// registered read port
always @(posedge sys_clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        rd_data_o <= {GW{1'b0}};
        rd_skip_o <= {`TSC_SKIP_W{1'b0}};
        rd_rel_o  <= {AW+1{1'b0}};
    end
    else
    begin
        {rd_skip_o, rd_data_o} <= mem[rd_addr];
        rd_rel_o <= $signed({1'b0, rd_idx_i}) - $signed({1'b0, trig_idx});
    end
end

endmodule // tsc_capture
`default_nettype wire

// ### logic/tsc_map.vh
`ifndef TSC_MAP_VH
`define TSC_MAP_VH

// trigger position codes
`define TSC_POS_EARLY 2'h0
`define TSC_POS_MIDDLE 2'h1
`define TSC_POS_LATE 2'h2

// shifts of buffer depth giving the short side of a split
`define TSC_MID_SHIFT 1
`define TSC_EDGE_SHIFT 3

// unchanged run length that forces a store
`define TSC_RUN_MAX 7'h40
`define TSC_SKIP_W 7

`endif

// ### logic/tsc_watch.v
`timescale 1ns/1ps
`default_nettype none
`include "tsc_map.vh"

module tsc_watch #(
    parameter W = 16
) (
    input  wire         sys_clk_i,
    input  wire         rst_i,
    input  wire         en_i,
    input  wire         trans_i,
    input  wire [W-1:0] first_i,
    input  wire [W-1:0] second_i,
    input  wire [W-1:0] care_i,
    input  wire [W-1:0] data_i,
    output wire         hit_o
);

// =====================================================
// value and transition compare
reg  [W-1:0] prev;
reg          prev_ok;
wire         now_first  = ((data_i ^ first_i) & care_i) == {W{1'b0}};
wire         now_second = ((data_i ^ second_i) & care_i) == {W{1'b0}};
wire         was_first  = ((prev ^ first_i) & care_i) == {W{1'b0}};

// previous cycle value, valid only while enabled
always @(posedge sys_clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        prev    <= {W{1'b0}};
        prev_ok <= 1'b0;
    end
    else
    begin
        prev    <= data_i;
        prev_ok <= en_i;
    end
end

// don't-care bits drop out of both compares
assign hit_o = en_i & (trans_i ? (prev_ok & was_first & now_second) : now_first);

endmodule // tsc_watch
`default_nettype wire

// ### bench/tsc_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// host side: arms the unit and acknowledges read-back
module tsc_host (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    input  wire logic go_i,
    input  wire logic ack_i,
    output var  logic arm_o,
    output var  logic rd_done_o
);
    // requests change just after the edge; settings already stand
    always @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            arm_o     <= 1'h0;
            rd_done_o <= 1'h0;
        end
        else
        begin
            arm_o     <= go_i;  // arm after setup
            rd_done_o <= ack_i; // release after read
        end
    end
endmodule // tsc_host
`default_nettype wire

// ### bench/tsc_capture_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port checker
module tsc_capture_monitor #(
    parameter AW = 4
) (
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    input wire logic        arm_i,
    input wire logic        stop_i,
    input wire logic        rd_done_i,
    input wire logic        running_o,
    input wire logic        new_data_o,
    input wire logic [AW:0] count_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    a_arm_starts_run: assert property (arm_i |=> running_o && !new_data_o && count_o == 0)
        else $error("run did not start");
    a_done_run_over: assert property ($rose(new_data_o) |-> !running_o)
        else $error("done while running");
    a_stop_halts_run: assert property (stop_i && !arm_i |=> !running_o)
        else $error("stop ignored");
    a_flag_holds: assert property (new_data_o && !rd_done_i && !arm_i |=> new_data_o)
        else $error("flag lost");
    a_read_clears: assert property (rd_done_i && !arm_i && !running_o |=> !new_data_o)
        else $error("flag not cleared");
    a_one_store: assert property (running_o && !arm_i |=>
        (count_o == $past(count_o) || count_o == $past(count_o) + 1'h1))
        else $error("count jumped");
    a_idle_frozen: assert property (!running_o && !arm_i |=> $stable(count_o))
        else $error("store while idle");
    a_count_cap: assert property (count_o <= (1 << AW))
        else $error("count past depth");
    c_done: cover property ($rose(new_data_o));
    c_stop: cover property (stop_i && running_o);
    c_read: cover property (rd_done_i && new_data_o);
endmodule // tsc_capture_monitor
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// capture unit bench
module tb;
    localparam AW = 4;
    reg           sys_clk = 1'h0;
    reg           rst = 1'h1;
    reg  [7:0]    dat = 8'h00;
    reg           frz = 1'h0, go = 1'h0, ack = 1'h0, stop = 1'h0, comp = 1'h0;
    reg  [1:0]    pos = 2'h1, bp_en = 2'h0, bp_hit = 2'h0, wp_en = 2'h0, sel = 2'h2;
    reg  [1:0]    wp_trans = 2'h0;
    reg  [15:0]   wp_first = 16'h0000, wp_second = 16'h0000, wp_care = 16'h0000;
    reg           msk = 1'h0;
    reg  [2:0]    msb = 3'h0, lsb = 3'h0;
    wire [31:0]   grp;
    reg  [AW-1:0] idx = 4'h0;
    reg  [7:0]    exp_d;
    wire          arm, rd_done, running, new_data, bp_trig;
    wire [0:0]    bp_idx;
    wire [AW:0]   count;
    wire [7:0]    rd_data;
    wire [6:0]    rd_skip;
    wire signed [AW:0] rd_rel;
    integer       num_errors = 0, tests_run = 0, cyc = 0, i;

    initial forever #50 sys_clk = ~sys_clk;
    // moving design data, or frozen with only bit 0 toggling
    always @(negedge sys_clk) dat <= frz ? {dat[7:1], ~dat[0]} : dat + 8'h01;
    // four groups, each a distinct pattern of the same counter
    assign grp = {dat ^ 8'h30, dat ^ 8'h20, dat ^ 8'h10, dat};

    tsc_host host (.sys_clk_i(sys_clk), .rst_i(rst), .go_i(go), .ack_i(ack),
        .arm_o(arm), .rd_done_o(rd_done));
    tsc_capture #(.GW(8), .NG(4), .SW(2), .AW(AW), .NWP(2), .NBP(2), .BW(1), .MW(3)) dut (
        .sys_clk_i(sys_clk), .rst_i(rst), .grp_data_i(grp),
        .grp_sel_i(sel), .arm_i(arm), .stop_i(stop), .wp_en_i(wp_en), .wp_trans_i(wp_trans),
        .wp_first_i(wp_first), .wp_second_i(wp_second), .wp_care_i(wp_care), .bp_en_i(bp_en),
        .bp_hit_i(bp_hit), .trig_pos_i(pos), .comp_en_i(comp), .mask_en_i(msk),
        .mask_msb_i(msb), .mask_lsb_i(lsb), .rd_idx_i(idx), .rd_done_i(rd_done),
        .running_o(running), .new_data_o(new_data), .bp_trig_o(bp_trig), .bp_idx_o(bp_idx),
        .count_o(count), .rd_data_o(rd_data), .rd_skip_o(rd_skip), .rd_rel_o(rd_rel));

    task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    begin
        tests_run = tests_run + 1;
        if (s !== e)
        begin
            num_errors = num_errors + 1;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    end
    endtask

    task arm_run(input logic c);
    begin
        comp = c;
        @(negedge sys_clk) go = 1'h1;
        @(negedge sys_clk) go = 1'h0;
    end
    endtask

    // breakpoint trigger at a given position; bp0 and both watches stay off
    task run_pos(input logic [1:0] p, input integer post, input logic [3:0] ti);
    begin
        pos = p;
        bp_en = 2'h2;
        bp_hit = 2'h1;
        arm_run(1'h0);
        repeat (24) @(negedge sys_clk);
        bp_hit = 2'h3;
        @(posedge sys_clk) exp_d = dat ^ 8'h20;
        @(negedge sys_clk) bp_hit = 2'h1;
        i = 0;
        while (new_data !== 1'h1 && i < 40)
        begin
            @(negedge sys_clk);
            i = i + 1;
        end
        chk("post", post, i); // split
        chk("count", 16'h0010, count); // full
        chk("bp", 16'h0003, {bp_trig, bp_idx}); // source
        idx = ti;
        @(negedge sys_clk);
        chk("rel", 16'h0000, rd_rel); // origin
        chk("data", exp_d, rd_data); // group
        ack = 1'h1;
        @(negedge sys_clk) ack = 1'h0;
        @(negedge sys_clk);
        chk("flag", 16'h0000, new_data); // cleared
        $display("done position %0d", p);
    end
    endtask

    // transition watch on group 1; watch 0 would hit at once if it leaked
    task run_watch;
    begin
        sel = 2'h1;
        pos = 2'h1;
        bp_en = 2'h0;
        wp_en = 2'h2;
        wp_trans = 2'h2;
        wp_first = 16'h30A5;
        wp_second = 16'h2000;
        wp_care = 16'hF000;
        @(posedge sys_clk);
        while (dat !== 8'h38)
            @(posedge sys_clk);
        arm_run(1'h0);
        i = 0;
        while (new_data !== 1'h1 && i < 300)
        begin
            @(negedge sys_clk);
            i = i + 1;
        end
        chk("wp_wait", 16'h00FF, i); // late edge only
        chk("wp_bp", 16'h0000, {bp_trig, bp_idx}); // no breakpoint
        idx = 4'h7;
        @(negedge sys_clk);
        chk("wp_data", 16'h0020, rd_data); // second value
        chk("wp_rel", 16'h0000, rd_rel); // origin
        idx = 4'h6;
        @(negedge sys_clk);
        chk("wp_prior", 16'h003F, rd_data); // first value
        chk("wp_rel_prior", 16'h001F, {rd_rel}); // minus one
        ack = 1'h1;
        @(negedge sys_clk) ack = 1'h0;
        @(negedge sys_clk);
        chk("wp_flag", 16'h0000, new_data); // cleared
        wp_en = 2'h0;
        sel = 2'h2;
        $display("done watchpoint");
    end
    endtask

    // constant data with masked toggling bit under compression
    task run_comp;
    begin
        frz = 1'h1;
        bp_en = 2'h0;
        wp_en = 2'h0;
        msk = 1'h1;
        msb = 3'h0;
        lsb = 3'h0;
        arm_run(1'h1);
        repeat (140) @(negedge sys_clk);
        chk("stores", 16'h0003, count); // sparse
        idx = 4'h1;
        @(negedge sys_clk);
        chk("skip", 16'h003F, rd_skip); // gap
        stop = 1'h1;
        @(negedge sys_clk) stop = 1'h0;
        @(negedge sys_clk);
        chk("halt", 16'h0000, {running, new_data}); // stopped
        msk = 1'h0;
        arm_run(1'h1);
        repeat (10) @(negedge sys_clk);
        chk("unmasked", 16'h0009, count); // mask cleared
        stop = 1'h1;
        @(negedge sys_clk) stop = 1'h0;
        @(negedge sys_clk);
        frz = 1'h0;
        $display("done compression");
    end
    endtask

    task final_report;
    begin
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask

    // hang guard
    always @(posedge sys_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            num_errors = num_errors + 1;
            final_report;
        end
    end

    initial
    begin
        repeat (16) @(negedge sys_clk);
        rst = 1'h0;
        @(negedge sys_clk);
        run_pos(2'h0, 14, 4'h1); // early
        run_pos(2'h1, 8, 4'h7); // middle
        run_pos(2'h2, 2, 4'hD); // late
        run_pos(2'h3, 8, 4'h7); // spare code as middle
        run_watch;
        run_comp;
        final_report;
    end
endmodule // tb

bind tsc_capture tsc_capture_monitor #(.AW(AW)) mon (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .arm_i(arm_i), .stop_i(stop_i), .rd_done_i(rd_done_i), .running_o(running_o),
    .new_data_o(new_data_o), .count_o(count_o));
`default_nettype wire
